// ===== pkg/sp9_pkg.sv
package sp9_pkg;

  // ----------------------------------------
  // Mode select codes {hi, lo}
  // ----------------------------------------
  localparam logic [1:0] SP9_MODE_SYNC8 = 2'h0;
  localparam logic [1:0] SP9_MODE_TMR10 = 2'h1;
  localparam logic [1:0] SP9_MODE_OSC11 = 2'h2;
  localparam logic [1:0] SP9_MODE_TMR11 = 2'h3;

  // ----------------------------------------
  // Bit slicing and voting
  // ----------------------------------------
  localparam int unsigned SP9_SLICES = 16;
  localparam logic [3:0] SP9_SLICE_LAST = 4'hf;
  localparam logic [3:0] SP9_VOTE_S1 = 4'h8;
  localparam logic [3:0] SP9_VOTE_S2 = 4'h9;
  localparam logic [3:0] SP9_VOTE_S3 = 4'ha;

  // ----------------------------------------
  // Rate dividers
  // ----------------------------------------
  // Oscillator/32 bit rate is oscillator/2 per slice, /64 is /4
  localparam logic [2:0] SP9_OSC_SLICE_FAST = 3'h2;
  localparam logic [2:0] SP9_OSC_SLICE_SLOW = 3'h4;
  // Synchronous mode shift period in clocks, clock low in the middle half
  localparam logic [3:0] SP9_M0_PERIOD_SLOW = 4'hc;
  localparam logic [3:0] SP9_M0_PERIOD_FAST = 4'h4;

  // ----------------------------------------
  // Frame sizes and reset values
  // ----------------------------------------
  localparam logic [3:0] SP9_FRAME10 = 4'ha;
  localparam logic [3:0] SP9_FRAME11 = 4'hb;
  localparam logic [3:0] SP9_DATA_BITS = 4'h8;
  localparam logic [3:0] SP9_NINE_BITS = 4'h9;
  localparam logic SP9_LINE_IDLE = 1'b1;
  localparam logic [7:0] SP9_BUF_RESET = 8'h00;

  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic [2:0] {
    SP9_TX_IDLE = 3'b001,
    SP9_TX_WAIT = 3'b010,
    SP9_TX_SEND = 3'b100
  } sp9_tx_state_t;

  typedef enum logic [3:0] {
    SP9_RX_HUNT = 4'b0001,
    SP9_RX_START = 4'b0010,
    SP9_RX_DATA = 4'b0100,
    SP9_RX_STOP = 4'b1000
  } sp9_rx_state_t;

  typedef enum logic [2:0] {
    SP9_M0_IDLE = 3'b001,
    SP9_M0_TX = 3'b010,
    SP9_M0_RX = 3'b100
  } sp9_m0_state_t;

endpackage

// ===== verilog/sp9_baud_tick.sv
`timescale 1ns/1ps
module sp9_baud_tick
  import sp9_pkg::*;
(
  input wire logic i_mclk, // Core clock
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic [1:0] i_mode, // Mode select {hi, lo}
  input wire logic i_baud_double_select, // Doubles the bit rate
  input wire logic i_timer1_overflow, // Timer overflow pulse
  output logic o_tick // One slice of sixteen per bit
);

  logic [2:0] div_r;
  logic [2:0] div_lim;
  logic ovf_half_r;

  assign div_lim = i_baud_double_select ? SP9_OSC_SLICE_FAST : SP9_OSC_SLICE_SLOW;

  // ----------------------------------------
  // Oscillator divider
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      div_r <= 3'h0;
    end else if (div_r >= div_lim - 3'h1) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // ----------------------------------------
  // Timer overflow halving
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ovf_half_r <= 1'b0;
    end else if (i_timer1_overflow) begin
      ovf_half_r <= ~ovf_half_r;
    end
  end

  always_comb begin
    if (i_mode == SP9_MODE_OSC11) begin
      o_tick = (div_r >= div_lim - 3'h1);
    end else begin
      o_tick = i_timer1_overflow && (i_baud_double_select || ovf_half_r);
    end
  end

endmodule // sp9_baud_tick

// ===== verilog/sp9_rx_vote.sv
`timescale 1ns/1ps
module sp9_rx_vote
  import sp9_pkg::*;
(
  input wire logic i_mclk, // Core clock
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic i_tick, // Slice tick
  input wire logic i_rxd, // Synchronised receive line
  input wire logic i_hunt, // Looking for a start edge
  output logic o_edge, // Falling edge found, pulse
  output logic o_bit_stb, // Bit decided, pulse
  output logic o_bit_val // Decided bit value
);

  logic prev_r;
  logic [3:0] cnt_r;
  logic [1:0] smp_r;

  function automatic logic vote3(input logic a, input logic b, input logic c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction

  assign o_edge = i_hunt && i_tick && prev_r && !i_rxd;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      prev_r <= SP9_LINE_IDLE;
    end else if (i_tick) begin
      prev_r <= i_rxd;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      cnt_r <= 4'h0;
    end else if (o_edge) begin
      cnt_r <= 4'h0;
    end else if (i_tick) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      smp_r <= 2'h0;
    end else if (i_tick && cnt_r == SP9_VOTE_S1) begin
      smp_r[0] <= i_rxd;
    end else if (i_tick && cnt_r == SP9_VOTE_S2) begin
      smp_r[1] <= i_rxd;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_bit_stb <= 1'b0;
      o_bit_val <= SP9_LINE_IDLE;
    end else begin
      o_bit_stb <= i_tick && !i_hunt && cnt_r == SP9_VOTE_S3;
      if (i_tick && cnt_r == SP9_VOTE_S3) begin
        o_bit_val <= vote3(smp_r[0], smp_r[1], i_rxd);
      end
    end
  end

endmodule // sp9_rx_vote

// ===== verilog/sp9_uart.sv
`timescale 1ns/1ps
module sp9_uart
  import sp9_pkg::*;
(
  input wire logic i_mclk, // Core clock, 10 MHz
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic i_mode_sel_hi, // Mode select high bit
  input wire logic i_mode_sel_lo, // Mode select low bit
  input wire logic i_multiproc_select, // Multiprocessor / sync fast rate
  input wire logic i_rx_enable, // Receive enable
  input wire logic i_baud_double_select, // Bit rate doubling
  input wire logic i_timer1_overflow, // Timer overflow pulse
  input wire logic i_tx_ninth_bit, // Ninth bit to send
  input wire logic i_buf_wr, // Serial buffer write strobe
  input wire logic [7:0] i_buf_wdata, // Serial buffer write data
  input wire logic i_tx_done_clr, // Clear tx done flag
  input wire logic i_rx_done_clr, // Clear rx done flag
  input wire logic i_rxd, // Receive pin level
  output logic o_txd, // Transmit pin / sync shift clock
  output logic o_rxd_out, // Receive pin drive in sync mode
  output logic o_rxd_oe, // Receive pin output enable
  output logic [7:0] o_serial_buffer, // Receive buffer read value
  output logic o_rx_ninth_bit, // Received ninth bit
  output logic o_tx_done_flag, // Transmit done flag
  output logic o_rx_done_flag, // Receive done flag
  output logic o_tx_busy, // Transmission in progress
  output logic o_rx_busy // Reception in progress
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] mode;
  logic async_mode;
  logic frame11;
  logic tick;
  logic rxd_m_r;
  logic rxd_s_r;
  logic rx_edge;
  logic bit_stb;
  logic bit_val;
  logic rx_hunt;

  sp9_tx_state_t tx_state_r;
  logic [3:0] tx_div_r;
  logic tx_roll;
  logic [9:0] tx_sr_r;
  logic [3:0] tx_cnt_r;
  logic tx_line_r;
  logic tx_frame_len;
  logic [3:0] tx_nbits;
  logic async_ti_set;

  sp9_rx_state_t rx_state_r;
  logic [8:0] rx_sr_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_nbits;
  logic async_load;
  logic [7:0] async_data;
  logic async_ninth;

  sp9_m0_state_t m0_state_r;
  logic [3:0] m0_phase_r;
  logic [3:0] m0_period;
  logic [3:0] m0_fall;
  logic [3:0] m0_rise;
  logic [3:0] m0_bits_r;
  logic [7:0] m0_sr_r;
  logic m0_clk_r;
  logic m0_bit_end;
  logic m0_last;
  logic m0_ti_set;
  logic m0_load;

  logic [7:0] rx_buf_r;
  logic rx_ninth_r;
  logic tx_done_r;
  logic rx_done_r;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // mode bit decode
  assign mode = {i_mode_sel_hi, i_mode_sel_lo};
  assign async_mode = (mode != SP9_MODE_SYNC8);
  assign frame11 = (mode == SP9_MODE_OSC11) || (mode == SP9_MODE_TMR11);
  assign tx_frame_len = frame11;
  assign tx_nbits = tx_frame_len ? SP9_FRAME11 : SP9_FRAME10;
  assign rx_nbits = frame11 ? SP9_NINE_BITS : SP9_DATA_BITS;

  // ----------------------------------------
  // Receive pin synchroniser
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rxd_m_r <= SP9_LINE_IDLE;
      rxd_s_r <= SP9_LINE_IDLE;
    end else begin
      rxd_m_r <= i_rxd;
      rxd_s_r <= rxd_m_r;
    end
  end

  // ----------------------------------------
  // Slice tick and bit voter
  // ----------------------------------------
  sp9_baud_tick u_tick (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_mode(mode),
    .i_baud_double_select(i_baud_double_select),
    .i_timer1_overflow(i_timer1_overflow),
    .o_tick(tick)
  );

  assign rx_hunt = (rx_state_r == SP9_RX_HUNT);

  sp9_rx_vote u_vote (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_tick(tick && async_mode && (i_rx_enable || !rx_hunt)),
    .i_rxd(rxd_s_r),
    .i_hunt(rx_hunt),
    .o_edge(rx_edge),
    .o_bit_stb(bit_stb),
    .o_bit_val(bit_val)
  );

  // ----------------------------------------
  // Transmit divide-by-16 counter
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      tx_div_r <= 4'h0;
    end else if (tick) begin
      tx_div_r <= tx_div_r + 4'h1;
    end
  end

  assign tx_roll = tick && (tx_div_r == SP9_SLICE_LAST);

  // ----------------------------------------
  // Asynchronous transmitter
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      tx_state_r <= SP9_TX_IDLE;
      tx_sr_r <= 10'h3ff;
      tx_cnt_r <= 4'h0;
      tx_line_r <= SP9_LINE_IDLE;
    end else begin
      case (tx_state_r)
        SP9_TX_IDLE: begin
          tx_line_r <= SP9_LINE_IDLE;
          if (i_buf_wr && async_mode) begin
            tx_sr_r <= {1'b1, (frame11 ? i_tx_ninth_bit : 1'b1), i_buf_wdata};
            tx_state_r <= SP9_TX_WAIT;
          end
        end
        SP9_TX_WAIT: begin
          if (tx_roll) begin
            tx_line_r <= 1'b0;
            tx_cnt_r <= 4'h1;
            tx_state_r <= SP9_TX_SEND;
          end
        end
        SP9_TX_SEND: begin
          if (tx_roll) begin
            if (tx_cnt_r == tx_nbits) begin
              tx_line_r <= SP9_LINE_IDLE;
              tx_state_r <= SP9_TX_IDLE;
            end else begin
              tx_line_r <= tx_sr_r[0];
              tx_sr_r <= {1'b1, tx_sr_r[9:1]};
              tx_cnt_r <= tx_cnt_r + 4'h1;
            end
          end
        end
        default: begin
          tx_state_r <= SP9_TX_IDLE;
          tx_line_r <= SP9_LINE_IDLE;
        end
      endcase
    end
  end

  assign async_ti_set = (tx_state_r == SP9_TX_SEND) && tx_roll && (tx_cnt_r == tx_nbits - 4'h1);

  // ----------------------------------------
  // Asynchronous receiver
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rx_state_r <= SP9_RX_HUNT;
      rx_sr_r <= 9'h000;
      rx_cnt_r <= 4'h0;
    end else begin
      case (rx_state_r)
        SP9_RX_HUNT: begin
          if (rx_edge && i_rx_enable && async_mode) begin
            rx_state_r <= SP9_RX_START;
          end
        end
        SP9_RX_START: begin
          if (bit_stb) begin
            if (bit_val) begin
              rx_state_r <= SP9_RX_HUNT;
            end else begin
              rx_cnt_r <= 4'h0;
              rx_state_r <= SP9_RX_DATA;
            end
          end
        end
        SP9_RX_DATA: begin
          if (bit_stb) begin
            rx_sr_r <= {bit_val, rx_sr_r[8:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == rx_nbits - 4'h1) begin
              rx_state_r <= SP9_RX_STOP;
            end
          end
        end
        SP9_RX_STOP: begin
          if (bit_stb) begin
            rx_state_r <= SP9_RX_HUNT;
          end
        end
        default: begin
          rx_state_r <= SP9_RX_HUNT;
        end
      endcase
    end
  end

  // Eight-bit frames leave data in the top of the shifter
  assign async_data = frame11 ? rx_sr_r[7:0] : rx_sr_r[8:1];
  assign async_ninth = frame11 ? rx_sr_r[8] : bit_val;
  assign async_load = (rx_state_r == SP9_RX_STOP) && bit_stb && !rx_done_r &&
                      (!i_multiproc_select || bit_val);

  // ----------------------------------------
  // Synchronous shift engine
  // ----------------------------------------
  assign m0_period = i_multiproc_select ? SP9_M0_PERIOD_FAST : SP9_M0_PERIOD_SLOW;
  assign m0_fall = {2'h0, m0_period[3:2]};
  assign m0_rise = m0_period - m0_fall;
  assign m0_bit_end = (m0_phase_r == m0_period - 4'h1);
  assign m0_last = m0_bit_end && (m0_bits_r == SP9_DATA_BITS - 4'h1);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      m0_state_r <= SP9_M0_IDLE;
      m0_phase_r <= 4'h0;
      m0_bits_r <= 4'h0;
      m0_sr_r <= 8'hff;
    end else begin
      case (m0_state_r)
        SP9_M0_IDLE: begin
          m0_phase_r <= 4'h0;
          m0_bits_r <= 4'h0;
          if (!async_mode && i_buf_wr) begin
            m0_sr_r <= i_buf_wdata;
            m0_state_r <= SP9_M0_TX;
          end else if (!async_mode && i_rx_enable && !rx_done_r) begin
            m0_state_r <= SP9_M0_RX;
          end
        end
        SP9_M0_TX, SP9_M0_RX: begin
          m0_phase_r <= m0_bit_end ? 4'h0 : m0_phase_r + 4'h1;
          if (m0_state_r == SP9_M0_RX && m0_phase_r == m0_rise) begin
            m0_sr_r <= {rxd_s_r, m0_sr_r[7:1]};
          end else if (m0_state_r == SP9_M0_TX && m0_bit_end) begin
            m0_sr_r <= {1'b1, m0_sr_r[7:1]};
          end
          if (m0_bit_end) begin
            m0_bits_r <= m0_bits_r + 4'h1;
          end
          if (m0_last || async_mode) begin
            m0_state_r <= SP9_M0_IDLE;
          end
        end
        default: begin
          m0_state_r <= SP9_M0_IDLE;
        end
      endcase
    end
  end

  // Shift clock low in the middle of each bit period
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      m0_clk_r <= SP9_LINE_IDLE;
    end else begin
      m0_clk_r <= !((m0_state_r != SP9_M0_IDLE) && !m0_bit_end &&
                    (m0_phase_r + 4'h1 >= m0_fall) && (m0_phase_r + 4'h1 < m0_rise));
    end
  end

  assign m0_ti_set = (m0_state_r == SP9_M0_TX) && m0_last;
  assign m0_load = (m0_state_r == SP9_M0_RX) && m0_last;

  // ----------------------------------------
  // Receive buffer and flags
  // ----------------------------------------
  // reads see receive buffer
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rx_buf_r <= SP9_BUF_RESET;
      rx_ninth_r <= 1'b0;
    end else if (async_load) begin
      rx_buf_r <= async_data;
      rx_ninth_r <= async_ninth;
    end else if (m0_load) begin
      // Last sample and load meet when the sample point is the bit end
      rx_buf_r <= (m0_phase_r == m0_rise) ? {rxd_s_r, m0_sr_r[7:1]} : m0_sr_r;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      tx_done_r <= 1'b0;
    end else if (async_ti_set || m0_ti_set) begin
      tx_done_r <= 1'b1;
    end else if (i_tx_done_clr) begin
      tx_done_r <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rx_done_r <= 1'b0;
    end else if (async_load || m0_load) begin
      rx_done_r <= 1'b1;
    end else if (i_rx_done_clr) begin
      rx_done_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_txd = async_mode ? tx_line_r : m0_clk_r;
  assign o_rxd_out = m0_sr_r[0];
  assign o_rxd_oe = (m0_state_r == SP9_M0_TX);
  assign o_serial_buffer = rx_buf_r;
  assign o_rx_ninth_bit = rx_ninth_r;
  assign o_tx_done_flag = tx_done_r;
  assign o_rx_done_flag = rx_done_r;
  assign o_tx_busy = (tx_state_r != SP9_TX_IDLE) || (m0_state_r == SP9_M0_TX);
  assign o_rx_busy = !rx_hunt || (m0_state_r == SP9_M0_RX);

endmodule // sp9_uart

// ===== verification/sp9_uart_properties.sv
`timescale 1ns/1ps
module sp9_uart_checker (
  input wire logic i_mclk, // Clock
  input wire logic i_resetn, // Reset
  input wire logic i_mode_sel_hi, // Mode hi
  input wire logic i_mode_sel_lo, // Mode lo
  input wire logic i_multiproc_select, // Multiproc
  input wire logic i_rx_enable, // Rx enable
  input wire logic i_baud_double_select, // Rate double
  input wire logic i_tx_done_clr, // Tx clear
  input wire logic o_txd, // Tx line
  input wire logic o_rxd_oe, // Rx drive
  input wire logic [7:0] o_serial_buffer, // Rx buffer
  input wire logic o_rx_ninth_bit, // Rx ninth
  input wire logic o_tx_done_flag, // Tx flag
  input wire logic o_rx_done_flag, // Rx flag
  input wire logic o_tx_busy, // Tx busy
  input wire logic o_rx_busy // Rx busy
);
  // ----
  // Port checks
  // ----
  logic asy;
  logic go;
  logic go_r;
  logic [9:0] bcnt_r;
  assign asy = i_mode_sel_hi | i_mode_sel_lo;
  assign go = o_tx_busy && (go_r || !o_txd);
  // Busy cycles since the start bit of the current frame
  always_ff @(posedge i_mclk) begin
    go_r <= go;
    bcnt_r <= go ? bcnt_r + 10'h001 : 10'h000;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  property p_idle; asy && !o_tx_busy |-> o_txd; endproperty
  property p_start; $rose(o_tx_busy) && asy |-> o_txd ##[1:500] !o_txd; endproperty
  property p_done; $rose(o_tx_done_flag) && asy |-> o_txd && o_tx_busy; endproperty
  property p_len;
    $fell(o_tx_busy) && i_mode_sel_hi && !i_mode_sel_lo && i_baud_double_select |-> bcnt_r == 10'h160;
  endproperty
  property p_tflag; o_tx_done_flag && !i_tx_done_clr |=> o_tx_done_flag; endproperty
  property p_rgate; asy && !i_rx_enable && !o_rx_busy |=> !o_rx_busy; endproperty
  property p_hold; o_rx_done_flag |=> $stable(o_serial_buffer) && $stable(o_rx_ninth_bit); endproperty
  property p_mp;
    $rose(o_rx_done_flag) && i_mode_sel_lo && !i_mode_sel_hi && i_multiproc_select |-> o_rx_ninth_bit;
  endproperty
  property p_oe; o_rxd_oe |-> !asy; endproperty
  a_idle: assert property (p_idle) else $error("tx line low while idle");
  a_start: assert property (p_start) else $error("no start bit");
  a_done: assert property (p_done) else $error("tx flag off stop bit");
  a_len: assert property (p_len) else $error("frame length wrong");
  a_tflag: assert property (p_tflag) else $error("tx flag lost");
  a_rgate: assert property (p_rgate) else $error("rx while disabled");
  a_hold: assert property (p_hold) else $error("buffer changed");
  a_mp: assert property (p_mp) else $error("load with stop low");
  a_oe: assert property (p_oe) else $error("rx pin driven");
  c_tx: cover property ($rose(o_tx_done_flag));
  c_rx: cover property ($rose(o_rx_done_flag));
  c_oe: cover property ($rose(o_rxd_oe));
endmodule // sp9_uart_checker
bind sp9_uart sp9_uart_checker u_chk (.i_mclk, .i_resetn, .i_mode_sel_hi, .i_mode_sel_lo,
  .i_multiproc_select, .i_rx_enable, .i_baud_double_select, .i_tx_done_clr, .o_txd, .o_rxd_oe,
  .o_serial_buffer, .o_rx_ninth_bit, .o_tx_done_flag, .o_rx_done_flag, .o_tx_busy, .o_rx_busy);

// ===== verification/sp9_remote_model.sv
`timescale 1ns/1ps
module sp9_remote_model (
  input wire logic i_mclk, // Clock
  input wire logic i_txd, // Line from port
  output logic o_rxd // Line to port
);
  // ----
  // Remote serial end
  // ----
  int bit_clks = 32;
  initial o_rxd = 1'b1;
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_mclk);
      #1 o_rxd = bits[i];
      repeat (bit_clks - 1) @(posedge i_mclk);
    end
    @(posedge i_mclk);
    #1 o_rxd = 1'b1;
  endtask
  // Short false start
  task automatic glitch(input int n);
    @(posedge i_mclk);
    #1 o_rxd = 1'b0;
    repeat (n) @(posedge i_mclk);
    #1 o_rxd = 1'b1;
    repeat (2 * bit_clks) @(posedge i_mclk);
  endtask
  // Sync mode: next bit after each falling shift clock
  task automatic shift_out(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge i_txd);
      #1 o_rxd = d[i];
    end
    @(posedge i_txd);
    #1 o_rxd = 1'b1;
  endtask
  // Sample mid bit
  task automatic catch(input int n, output logic [10:0] bits);
    bits = '0;
    @(negedge i_txd);
    repeat (bit_clks / 2) @(posedge i_mclk);
    for (int i = 0; i < n; i++) begin
      bits[i] = i_txd;
      repeat (bit_clks) @(posedge i_mclk);
    end
  endtask
endmodule // sp9_remote_model

// ===== verification/test_serial_port_nine_bit_uart.sv
`timescale 1ns/1ps
module test_serial_port_nine_bit_uart;
  import sp9_pkg::*;
  // ----
  // Bench
  // ----
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic mhi = 1'b0;
  logic mlo = 1'b0;
  logic mp = 1'b0;
  logic ren = 1'b0;
  logic dbl = 1'b0;
  logic ovf = 1'b0;
  logic tx9 = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic tclr = 1'b0;
  logic rclr = 1'b0;
  logic rxd, txd, rdo, oe, rx9, tdone, rdone, tbusy, rbusy;
  logic [7:0] rbuf;
  logic [7:0] exp_buf = 8'h00;
  logic exp9 = 1'b0;
  logic rf = 1'b0;
  int ocnt = 0;
  int n_fail = 0;
  int n_tests = 0;

  sp9_uart DUT (.i_mclk(clk), .i_resetn(resetn), .i_mode_sel_hi(mhi), .i_mode_sel_lo(mlo),
    .i_multiproc_select(mp), .i_rx_enable(ren), .i_baud_double_select(dbl), .i_timer1_overflow(ovf),
    .i_tx_ninth_bit(tx9), .i_buf_wr(wr), .i_buf_wdata(wd), .i_tx_done_clr(tclr), .i_rx_done_clr(rclr),
    .i_rxd(rxd), .o_txd(txd), .o_rxd_out(rdo), .o_rxd_oe(oe), .o_serial_buffer(rbuf),
    .o_rx_ninth_bit(rx9), .o_tx_done_flag(tdone), .o_rx_done_flag(rdone), .o_tx_busy(tbusy),
    .o_rx_busy(rbusy));
  sp9_remote_model rm (.i_mclk(clk), .i_txd(txd), .o_rxd(rxd));

  initial forever #50 clk = ~clk;
  // Timer overflow every third clock
  always @(posedge clk) begin
    #1 ovf = (ocnt == 2);
    ocnt = (ocnt + 1) % 3;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic setup(input logic [1:0] m, input logic d, input logic p, input logic e, input int bc);
    @(posedge clk);
    #1 {mhi, mlo} = m;
    dbl = d;
    mp = p;
    ren = e;
    rm.bit_clks = bc;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr_buf(input logic [7:0] d, input logic b9);
    @(posedge clk);
    #1 wr = 1'b1;
    wd = d;
    tx9 = b9;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask
  task automatic clr_flags;
    @(posedge clk);
    #1 tclr = 1'b1;
    rclr = 1'b1;
    @(posedge clk);
    #1 tclr = 1'b0;
    rclr = 1'b0;
    rf = 1'b0;
  endtask
  task automatic t_tx(input logic [1:0] m, input logic d, input int bc, input logic [7:0] v, input logic b9);
    logic [10:0] f;
    logic [15:0] e;
    int n;
    n = (m == SP9_MODE_TMR10) ? 10 : 11;
    e = (n == 11) ? {5'h00, 1'b1, b9, v, 1'b0} : {6'h00, 1'b1, v, 1'b0};
    setup(m, d, 1'b0, 1'b0, bc);
    clr_flags;
    fork
      rm.catch(n, f);
      begin
        wr_buf(v, b9);
        repeat (3 * bc) @(posedge clk);
        wr_buf(~v, ~b9);
      end
    join
    check({5'h00, f}, e);
    check({tdone, tbusy}, 2'b10);
  endtask
  task automatic t_rx(input logic [1:0] m, input logic p, input logic e, input logic [7:0] v,
    input logic b9, input logic st, input logic ld);
    logic [10:0] f;
    int n;
    n = (m == SP9_MODE_TMR10) ? 10 : 11;
    f = (n == 11) ? {st, b9, v, 1'b0} : {1'b0, st, v, 1'b0};
    setup(m, 1'b1, p, e, (m == SP9_MODE_OSC11) ? 32 : 48);
    rm.send(f, n);
    repeat (4) @(posedge clk);
    if (ld) begin
      exp_buf = v;
      exp9 = (n == 11) ? b9 : st;
      rf = 1'b1;
    end
    check(rdone, rf);
    check({rx9, rbuf}, {exp9, exp_buf});
  endtask
  task automatic t_sync;
    logic [7:0] g;
    setup(SP9_MODE_SYNC8, 1'b0, 1'b0, 1'b0, 4);
    clr_flags;
    fork
      wr_buf(8'h96, 1'b0);
      for (int i = 0; i < 8; i++) begin
        @(posedge txd);
        g[i] = rdo;
        check(oe, 1'b1);
      end
    join
    repeat (8) @(posedge clk);
    check({tdone, g}, 9'h196);
    fork
      rm.shift_out(8'h5c);
      setup(SP9_MODE_SYNC8, 1'b0, 1'b1, 1'b1, 4);
    join
    repeat (8) @(posedge clk);
    check({rdone, rbuf}, 9'h15c);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    @(posedge clk);
    #1 check({txd, oe, tdone, rdone, rbuf}, 12'h800);
    t_tx(SP9_MODE_OSC11, 1'b1, 32, 8'ha5, 1'b1);
    t_tx(SP9_MODE_OSC11, 1'b0, 64, 8'h3c, 1'b0);
    t_tx(SP9_MODE_TMR11, 1'b1, 48, 8'h81, 1'b1);
    t_tx(SP9_MODE_TMR10, 1'b0, 96, 8'h7e, 1'b0);
    t_rx(SP9_MODE_OSC11, 1'b0, 1'b1, 8'ha5, 1'b1, 1'b1, 1'b1);
    t_rx(SP9_MODE_OSC11, 1'b0, 1'b1, 8'h3c, 1'b0, 1'b1, 1'b0);
    clr_flags;
    t_rx(SP9_MODE_TMR10, 1'b1, 1'b1, 8'h55, 1'b0, 1'b0, 1'b0);
    t_rx(SP9_MODE_TMR10, 1'b1, 1'b1, 8'h81, 1'b0, 1'b1, 1'b1);
    clr_flags;
    t_rx(SP9_MODE_TMR11, 1'b0, 1'b0, 8'h99, 1'b1, 1'b1, 1'b0);
    t_rx(SP9_MODE_TMR11, 1'b0, 1'b1, 8'h5a, 1'b0, 1'b0, 1'b1);
    clr_flags;
    rm.glitch(6);
    t_rx(SP9_MODE_TMR11, 1'b0, 1'b1, 8'hc3, 1'b1, 1'b1, 1'b1);
    clr_flags;
    t_sync;
    stop_test;
  end
endmodule // test_serial_port_nine_bit_uart
